// ### design/prescaled_down_timer_defines.svh
// constants for the prescaled down timer
`ifndef PRESCALED_DOWN_TIMER_DEFINES_SVH
`define PRESCALED_DOWN_TIMER_DEFINES_SVH
`define TMR_COUNT_POR 8'hF0
`define TMR_BIT_FLAG 7
`define TMR_BIT_MASK 6
`define TMR_BIT_SRC 5
`define TMR_BIT_EXT 4
`define TMR_BIT_PCLR 3
`define TMR_PSC_WIDTH 7
`endif

// ### design/prescaled_down_timer_pkg.sv
// types shared by the prescaled down timer
package prescaled_down_timer_pkg;
    typedef struct packed {
        logic irq_request_flag;
        logic irq_mask_bit;
        logic source_select_bit;
        logic external_enable_bit;
        logic prescaler_clear_bit;
        logic [2:0] prescale_sel;
    } timer_control_t;
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_GATED = 2'b01,
        SRC_OFF = 2'b10,
        SRC_PIN = 2'b11
    } src_mode_t;
endpackage : prescaled_down_timer_pkg

// ### design/prescaled_down_timer.sv
// prescaled 8-bit down timer with control register
`timescale 1ns/1ps
`default_nettype none
`include "prescaled_down_timer_defines.svh"

module prescaled_down_timer #(
    parameter int PSC_WIDTH = `TMR_PSC_WIDTH
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic stop_mode,
    input wire logic cycle_tick,
    input wire logic timer_pin,
    input wire logic write_strobe_phase,
    input wire logic counter_sel,
    input wire logic control_sel,
    input wire logic [7:0] write_data,
    output logic [7:0] counter_value,
    output logic [7:0] control_value,
    output logic timer_irq
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] pin_sync;
    logic pin_level;
    always_ff @(posedge mclk) begin
        pin_sync <= {pin_sync[1:0], timer_pin};
        if (pin_sync[2] == pin_sync[1]) begin
            pin_level <= pin_sync[2];
        end
    end
    logic pin_prev;
    always_ff @(posedge mclk) begin
        pin_prev <= pin_level;
    end
    wire pin_fall = pin_prev & ~pin_level;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    prescaled_down_timer_pkg::timer_control_t ctrl;
    logic [7:0] count;
    logic [PSC_WIDTH-1:0] psc;
    logic tap_prev;
    wire wr_count = write_strobe_phase & counter_sel;
    wire wr_ctrl = write_strobe_phase & control_sel;
    wire hard_clear = ~reset_n | ~por_n | stop_mode;
    wire [1:0] mode_bits = {ctrl.source_select_bit, ctrl.external_enable_bit};
    prescaled_down_timer_pkg::src_mode_t mode;
    assign mode = prescaled_down_timer_pkg::src_mode_t'(mode_bits);

    // input pulse selection per mode
    logic src_pulse;
    always_comb begin
        case (mode)
            prescaled_down_timer_pkg::SRC_INTERNAL: src_pulse = cycle_tick;
            prescaled_down_timer_pkg::SRC_GATED: src_pulse = cycle_tick & pin_level;
            prescaled_down_timer_pkg::SRC_OFF: src_pulse = 1'b0;
            prescaled_down_timer_pkg::SRC_PIN: src_pulse = pin_fall;
            default: src_pulse = 1'b0;
        endcase
    end

    // divide by 1 taps the input pulse directly; others a prescaler bit
    wire [PSC_WIDTH:0] taps = {psc, src_pulse};
    wire tap = taps[ctrl.prescale_sel];
    wire dec_pulse = (ctrl.prescale_sel == 3'h0) ? src_pulse : (tap & ~tap_prev);
    // power-on clears too, so the divider never starts from an unknown value
    wire psc_clear = stop_mode | ~por_n | (wr_ctrl & write_data[`TMR_BIT_PCLR]);
    wire hit_zero = dec_pulse & ~wr_count & ~stop_mode & (count == 8'h01);

    always_ff @(posedge mclk) begin
        if (psc_clear) begin
            psc <= '0;
            tap_prev <= 1'b0;
        end else begin
            if (src_pulse) begin
                psc <= psc + 1'b1;
            end
            tap_prev <= tap;
        end
    end

    // source, enable and prescale select have no reset: they survive reset
    always_ff @(posedge mclk) begin
        if (wr_ctrl) begin
            ctrl.source_select_bit <= write_data[`TMR_BIT_SRC];
            ctrl.external_enable_bit <= write_data[`TMR_BIT_EXT];
            ctrl.prescale_sel <= write_data[2:0];
        end
        ctrl.prescaler_clear_bit <= 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (hard_clear) begin
            ctrl.irq_request_flag <= 1'b0;
            ctrl.irq_mask_bit <= 1'b1;
        end else begin
            // hardware set wins over software clear
            ctrl.irq_request_flag <= hit_zero
                | (wr_ctrl ? write_data[`TMR_BIT_FLAG] : ctrl.irq_request_flag);
            if (wr_ctrl) begin
                ctrl.irq_mask_bit <= write_data[`TMR_BIT_MASK];
            end
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (~por_n | stop_mode) begin
            count <= `TMR_COUNT_POR;
        end else if (wr_count) begin
            count <= write_data;
        end else if (dec_pulse) begin
            count <= count - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        counter_value <= count;
        control_value <= {ctrl.irq_request_flag, ctrl.irq_mask_bit,
                          ctrl.source_select_bit, ctrl.external_enable_bit,
                          1'b0, ctrl.prescale_sel};
        timer_irq <= ctrl.irq_request_flag & ~ctrl.irq_mask_bit;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_irq_follows;
        @(posedge mclk) disable iff (!reset_n)
        ##1 timer_irq == $past(ctrl.irq_request_flag & ~ctrl.irq_mask_bit);
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

    property p_zero_sets_flag;
        @(posedge mclk) disable iff (!reset_n || !por_n)
        hit_zero |=> ctrl.irq_request_flag && count == 8'h00;
    endproperty
    a_zero_sets_flag: assert property (p_zero_sets_flag) else $error("flag not set");

    property p_stop_clears;
        @(posedge mclk) stop_mode |=> count == `TMR_COUNT_POR && ctrl.irq_mask_bit
            && !ctrl.irq_request_flag && psc == '0;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop effect missing");

    property p_write_load;
        @(posedge mclk) disable iff (!reset_n)
        wr_count && por_n && !stop_mode |=> count == $past(write_data);
    endproperty
    a_write_load: assert property (p_write_load) else $error("counter load failed");

    property p_off_holds;
        @(posedge mclk) disable iff (!reset_n)
        mode == prescaled_down_timer_pkg::SRC_OFF && !wr_count && !stop_mode && por_n
            |=> $stable(count);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("count moved while off");

    property p_wrap;
        @(posedge mclk) disable iff (!reset_n)
        count == 8'h00 && dec_pulse && !wr_count && !stop_mode && por_n |=> count == 8'hFF;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");

    property p_pclr_reads_zero;
        @(posedge mclk) disable iff (!reset_n)
        control_value[3] == 1'b0;
    endproperty
    a_pclr_reads_zero: assert property (p_pclr_reads_zero) else $error("bit 3 nonzero");

    property p_masked_flag;
        @(posedge mclk) disable iff (!reset_n)
        ctrl.irq_mask_bit && ctrl.irq_request_flag |=> !timer_irq;
    endproperty
    a_masked_flag: assert property (p_masked_flag) else $error("masked irq seen");

    property p_masked_sets;
        @(posedge mclk) disable iff (!reset_n || !por_n)
        hit_zero && ctrl.irq_mask_bit |=> ctrl.irq_request_flag;
    endproperty
    a_masked_sets: assert property (p_masked_sets) else $error("masked flag not set");

    property p_write_one;
        @(posedge mclk) disable iff (!reset_n || !por_n)
        wr_ctrl && write_data[`TMR_BIT_FLAG] && !stop_mode |=> ctrl.irq_request_flag;
    endproperty
    a_write_one: assert property (p_write_one) else $error("flag write ignored");

    property p_flag_sticky;
        @(posedge mclk) disable iff (!reset_n || !por_n)
        ctrl.irq_request_flag && !wr_ctrl && !stop_mode |=> ctrl.irq_request_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_mask_sticky;
        @(posedge mclk) disable iff (!reset_n)
        ctrl.irq_mask_bit && !wr_ctrl |=> ctrl.irq_mask_bit;
    endproperty
    a_mask_sticky: assert property (p_mask_sticky) else $error("mask dropped");

    // ------------------------------------------------------------
    // assertions: control register and resets
    // ------------------------------------------------------------
    property p_ctrl_write;
        @(posedge mclk) disable iff (!reset_n || !por_n)
        wr_ctrl && !stop_mode |=> ctrl.irq_mask_bit == $past(write_data[`TMR_BIT_MASK])
            && ctrl.source_select_bit == $past(write_data[`TMR_BIT_SRC])
            && ctrl.external_enable_bit == $past(write_data[`TMR_BIT_EXT])
            && ctrl.prescale_sel == $past(write_data[2:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_reset_keeps;
        @(posedge mclk) disable iff (!por_n)
        !reset_n && !wr_ctrl |=> $stable(ctrl.source_select_bit)
            && $stable(ctrl.external_enable_bit);
    endproperty
    a_reset_keeps: assert property (p_reset_keeps) else $error("source bits reset");

    property p_reset_keeps_sel;
        @(posedge mclk) disable iff (!por_n)
        !reset_n && !wr_ctrl |=> $stable(ctrl.prescale_sel);
    endproperty
    a_reset_keeps_sel: assert property (p_reset_keeps_sel) else $error("select reset");

    property p_por_loads;
        @(posedge mclk) !por_n |=> count == `TMR_COUNT_POR && ctrl.irq_mask_bit
            && !ctrl.irq_request_flag;
    endproperty
    a_por_loads: assert property (p_por_loads) else $error("power-on load missing");

    property p_pclr_clears;
        @(posedge mclk) wr_ctrl && write_data[`TMR_BIT_PCLR] |=> psc == '0;
    endproperty
    a_pclr_clears: assert property (p_pclr_clears) else $error("prescaler not cleared");

    // ------------------------------------------------------------
    // assertions: count path and clock sources
    // ------------------------------------------------------------
    property p_decrement;
        @(posedge mclk) disable iff (!por_n)
        dec_pulse && !wr_count && !stop_mode |=> count == $past(count) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("no decrement");

    property p_hold;
        @(posedge mclk) disable iff (!por_n)
        !dec_pulse && !wr_count && !stop_mode |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without pulse");

    property p_read_reg;
        @(posedge mclk) disable iff (!por_n)
        ##1 counter_value == $past(count);
    endproperty
    a_read_reg: assert property (p_read_reg) else $error("read value wrong");

    property p_psc_step;
        @(posedge mclk) disable iff (!por_n)
        src_pulse && !psc_clear |=> psc == $past(psc) + 1'b1;
    endproperty
    a_psc_step: assert property (p_psc_step) else $error("prescaler did not step");

    property p_off_psc;
        @(posedge mclk) disable iff (!por_n)
        mode == prescaled_down_timer_pkg::SRC_OFF && !psc_clear |=> $stable(psc);
    endproperty
    a_off_psc: assert property (p_off_psc) else $error("prescaler ran while off");

    property p_internal_src;
        @(posedge mclk) disable iff (!por_n)
        mode == prescaled_down_timer_pkg::SRC_INTERNAL |-> src_pulse == cycle_tick;
    endproperty
    a_internal_src: assert property (p_internal_src) else $error("internal source wrong");

    property p_gated_src;
        @(posedge mclk) disable iff (!por_n)
        mode == prescaled_down_timer_pkg::SRC_GATED |-> src_pulse == (cycle_tick && pin_level);
    endproperty
    a_gated_src: assert property (p_gated_src) else $error("gated source wrong");

    property p_pin_src;
        @(posedge mclk) disable iff (!por_n)
        mode == prescaled_down_timer_pkg::SRC_PIN |-> src_pulse == (pin_prev && !pin_level);
    endproperty
    a_pin_src: assert property (p_pin_src) else $error("pin source wrong");

    // a pin change counts only once two stages agree
    property p_sync_agree;
        @(posedge mclk) pin_sync[2] != pin_sync[1] |=> $stable(pin_level);
    endproperty
    a_sync_agree: assert property (p_sync_agree) else $error("pin level moved early");
endmodule : prescaled_down_timer
`default_nettype wire

// ### testbench/cpu_core_model.sv
// processor core stand-in: instruction cycle ticks and register writes
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model #(
    parameter int TICK_PERIOD = 4
) (
    input wire logic mclk,
    output logic cycle_tick,
    output logic write_strobe_phase,
    output logic counter_sel,
    output logic control_sel,
    output logic [7:0] write_data
);
    int phase = 0;
    initial begin
        cycle_tick = 1'b0;
        write_strobe_phase = 1'b0;
        counter_sel = 1'b0;
        control_sel = 1'b0;
        write_data = 8'h00;
    end
    always @(posedge mclk) begin
        phase <= (phase == TICK_PERIOD - 1) ? 0 : phase + 1;
        cycle_tick <= (phase == TICK_PERIOD - 1);
    end
    // released bus shows the inverse so a stale byte cannot pass for a write
    task automatic write(input logic to_ctr, input logic [7:0] d);
        @(posedge mclk);
        write_strobe_phase <= 1'b1;
        counter_sel <= to_ctr;
        control_sel <= ~to_ctr;
        write_data <= d;
        @(posedge mclk);
        write_strobe_phase <= 1'b0;
        counter_sel <= 1'b0;
        control_sel <= 1'b0;
        write_data <= ~d;
        repeat (2) @(posedge mclk);
        #1;
    endtask : write
endmodule : cpu_core_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the prescaled down timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic por_n = 1'b0;
    logic stop_mode = 1'b0;
    logic timer_pin = 1'b0;
    wire logic cycle_tick, write_strobe_phase, counter_sel, control_sel, timer_irq;
    wire logic [7:0] write_data, counter_value, control_value;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    always #4 mclk = ~mclk;
    cpu_core_model cpu_core_model_i (.mclk(mclk), .cycle_tick(cycle_tick),
        .write_strobe_phase(write_strobe_phase), .counter_sel(counter_sel),
        .control_sel(control_sel), .write_data(write_data));
    prescaled_down_timer prescaled_down_timer_i (.mclk(mclk), .reset_n(reset_n), .por_n(por_n),
        .stop_mode(stop_mode), .cycle_tick(cycle_tick), .timer_pin(timer_pin),
        .write_strobe_phase(write_strobe_phase), .counter_sel(counter_sel),
        .control_sel(control_sel), .write_data(write_data), .counter_value(counter_value),
        .control_value(control_value), .timer_irq(timer_irq));
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // a hang would otherwise stop the run without a verdict
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    // cycles until the visible count moves, bounded
    task automatic step(output int n);
        logic [7:0] old;
        old = counter_value;
        n = 0;
        while (counter_value === old && n < 3000) begin
            wt(1);
            n++;
        end
    endtask : step
    task automatic t_regs();
        chk(control_value[7:6], 2'b01);
        chk(timer_irq, 1'b0);
        cpu_core_model_i.write(1'b0, 8'h2F);
        chk(control_value[3], 1'b0);
        chk(control_value, 8'h27);
        cpu_core_model_i.write(1'b1, 8'h05);
        wt(30);
        chk(counter_value, 8'h05);
    endtask : t_regs
    task automatic t_zero(input logic [7:0] ctl);
        int n;
        int k;
        logic [7:0] v;
        cpu_core_model_i.write(1'b1, 8'h03);
        cpu_core_model_i.write(1'b0, ctl);
        // a tick may land inside the write, so count steps from what is shown
        v = counter_value;
        k = 0;
        while (counter_value !== 8'h00 && k < 8) begin
            step(n);
            k++;
        end
        chk(counter_value, 8'h00);
        chk(16'(k), 16'(v));
        chk(16'(n), 16'h0004);
        wt(2);
        chk(control_value[7], 1'b1);
        chk(timer_irq, !ctl[6]);
        step(n);
        chk(counter_value, 8'hFF);
        cpu_core_model_i.write(1'b0, ctl);
        chk(control_value[7], 1'b0);
        chk(timer_irq, 1'b0);
    endtask : t_zero
    task automatic t_psc();
        int n;
        for (int s = 0; s < 8; s++) begin
            cpu_core_model_i.write(1'b0, 8'h48 | 8'(s));
            step(n);
            step(n);
            chk(16'(n), 16'(4 << s));
        end
    endtask : t_psc
    task automatic t_ext();
        logic [7:0] v;
        cpu_core_model_i.write(1'b0, 8'h50);
        wt(20);
        v = counter_value;
        wt(40);
        chk(counter_value, v);
        @(posedge mclk);
        timer_pin <= 1'b1;
        wt(10);
        v = counter_value;
        wt(40);
        chk(counter_value, 8'(v - 8'h0A));
        @(posedge mclk);
        timer_pin <= 1'b0;
        cpu_core_model_i.write(1'b0, 8'h70);
        wt(10);
        v = counter_value;
        repeat (3) begin
            @(posedge mclk);
            timer_pin <= 1'b1;
            wt(10);
            @(posedge mclk);
            timer_pin <= 1'b0;
            wt(10);
        end
        chk(counter_value, 8'(v - 8'h03));
    endtask : t_ext
    task automatic t_reset();
        cpu_core_model_i.write(1'b0, 8'hB5);
        chk(control_value, 8'hB5);
        chk(timer_irq, 1'b1);
        @(posedge mclk);
        reset_n <= 1'b0;
        wt(2);
        @(posedge mclk);
        reset_n <= 1'b1;
        wt(2);
        chk(control_value, 8'h75);
        chk(timer_irq, 1'b0);
        @(posedge mclk);
        stop_mode <= 1'b1;
        wt(20);
        chk(counter_value, 8'hF0);
        chk(control_value[7:6], 2'b01);
        @(posedge mclk);
        stop_mode <= 1'b0;
        cpu_core_model_i.write(1'b1, 8'h11);
        @(posedge mclk);
        por_n <= 1'b0;
        wt(3);
        @(posedge mclk);
        por_n <= 1'b1;
        wt(1);
        chk(counter_value, 8'hF0);
    endtask : t_reset
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        wt(1);
        t_regs();
        t_zero(8'h08);
        cpu_core_model_i.write(1'b0, 8'h60);
        t_zero(8'h40);
        t_psc();
        t_ext();
        t_reset();
        final_report();
    end
endmodule : tb
`default_nettype wire
